// [pkg/fspc_pkg.sv]
/*
  Shared constants for the flash self-programming controller: control/status
  register layout and offsets, flash geometry, section limits, boot sizes and
  command window and programming time figures.
  Assumes a single core clock at 10 MHz standing in for the calibrated oscillator.
*/
package fspc_pkg;

  // ---------------------------------------------------------------
  // Register placement
  // ---------------------------------------------------------------
  localparam logic [7:0] CSR_DATA_OFS = 8'h57;
  localparam logic [7:0] IO_OFS_DELTA = 8'h20;
  localparam logic [7:0] CSR_IO_OFS = CSR_DATA_OFS - IO_OFS_DELTA;
  localparam logic [7:0] CSR_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Control/status bit positions
  // ---------------------------------------------------------------
  localparam int BIT_ARM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_LOCK = 3;
  localparam int BIT_REEN = 4;
  localparam int BIT_SIG = 5;
  localparam int BIT_BUSY = 6;
  localparam int BIT_IRQ_EN = 7;

  // ---------------------------------------------------------------
  // Flash geometry
  // ---------------------------------------------------------------
  localparam int PC_WIDTH = 13;
  localparam int COUNTER_TOP_BIT = 12;
  localparam int PAGE_WORD_TOP_BIT = 5;
  localparam int WORD_SEL_WIDTH = PAGE_WORD_TOP_BIT + 1;
  localparam int PAGE_SEL_WIDTH = COUNTER_TOP_BIT - PAGE_WORD_TOP_BIT;
  localparam int PTR_WORD_LSB = 1;
  localparam int PTR_PAGE_LSB = PAGE_WORD_TOP_BIT + 2;
  localparam int PTR_PAGE_MSB = COUNTER_TOP_BIT + 1;
  localparam int BYTE_SEL_BIT = 0;

  // ---------------------------------------------------------------
  // Section limits (word addresses, page count) and boot sizes (words)
  // ---------------------------------------------------------------
  localparam logic [12:0] CONC_SECTION_LAST = 13'h1bff;
  localparam logic [12:0] HALT_SECTION_FIRST = 13'h1c00;
  localparam logic [6:0] CONC_SECTION_PAGES = 7'h70;
  localparam logic [12:0] BOOT_START_128 = 13'h1f80;
  localparam logic [12:0] BOOT_START_256 = 13'h1f00;
  localparam logic [12:0] BOOT_START_512 = 13'h1e00;
  localparam logic [12:0] BOOT_START_1024 = 13'h1c00;
  localparam logic [10:0] BOOT_WORDS_128 = 11'h080;
  localparam logic [10:0] BOOT_WORDS_256 = 11'h100;
  localparam logic [10:0] BOOT_WORDS_512 = 11'h200;
  localparam logic [10:0] BOOT_WORDS_1024 = 11'h400;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int STORE_WINDOW_CYCLES = 4;
  localparam int LOAD_WINDOW_CYCLES = 3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_MIN_NS = 3200000;
  localparam int PROG_TIME_MAX_NS = 3400000;
  // Least time rounds up, longest rounds down
  localparam int PROG_CYCLES_MIN = (PROG_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES_MAX = PROG_TIME_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FSPC_OP_IDLE = 2'b00,
    FSPC_OP_ERASE = 2'b01,
    FSPC_OP_WRITE = 2'b10,
    FSPC_OP_LOCK = 2'b11
  } fspc_op_t;

endpackage

// [rtl/fspc_prog_timer.sv]
/*
  Programming time counter: one start pulse runs it for CYCLES clocks,
  then a one-cycle done pulse.
  Assumes start is only given while idle.
*/
`timescale 1ns/100ps
module fspc_prog_timer import fspc_pkg::*; #(
  parameter int CYCLES = PROG_CYCLES_MIN
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  output logic busy,
  output logic done
);

  logic [15:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
    end else if (start && !busy_ff) begin
      cnt_ff <= 16'(CYCLES - 1);
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff == 16'h0000) begin
        busy_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff && (cnt_ff == 16'h0000);
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;

endmodule

// [rtl/fspc_section_map.sv]
/*
  Address decode for self-programming: boot section start and size from the
  boot size fuse, and which section a page belongs to.
  Assumes the fuse is static while the block runs.
*/
`timescale 1ns/100ps
module fspc_section_map import fspc_pkg::*; (
  input wire logic [1:0] boot_size_fuse,
  input wire logic [PAGE_SEL_WIDTH-1:0] page_sel,
  output logic [12:0] boot_start_addr,
  output logic [10:0] boot_words,
  output logic page_in_conc
);

  always_comb begin
    unique case (boot_size_fuse)
      2'b11: begin
        boot_start_addr = BOOT_START_128;
        boot_words = BOOT_WORDS_128;
      end
      2'b10: begin
        boot_start_addr = BOOT_START_256;
        boot_words = BOOT_WORDS_256;
      end
      2'b01: begin
        boot_start_addr = BOOT_START_512;
        boot_words = BOOT_WORDS_512;
      end
      2'b00: begin
        boot_start_addr = BOOT_START_1024;
        boot_words = BOOT_WORDS_1024;
      end
    endcase
  end

  // Pages below the halting section limit may be read while programming
  assign page_in_conc = ({page_sel, 6'h00} <= CONC_SECTION_LAST);

endmodule

// [rtl/fspc_top.sv]
/*
  Flash self-programming controller: control/status register, armed command
  window, page buffer fill, page erase and write, lock programming, special
  loads, concurrent section busy tracking and the ready interrupt request.
  Assumes the core gives one-cycle store/load request pulses with pointer and
  data stable in that cycle, and a flash array that obeys the start pulses.
*/
// How it works
// - Boot size fuse picks boot section size and start address.
// - Words 0x0000-0x1BFF read while writing; 0x1C00-0x1FFF halt the core.
// - Pointer bits 6..1 select the word within a 64-word page.
// - Pointer bits 13..7 select the page for erase and write.
// - Pointer bits 15..14 ignored; bit 0 is the load byte select.
// - Register at data offset 0x57, I/O offset 0x37, resets to zero.
// - Ready request stands while enable and global enable set, arm clear.
// - Erase or write to concurrent section sets busy flag, blocks reads.
// - Busy flag clears on re-enable after programming or on buffer load.
// - Signature read arms a load within three cycles; store does nothing.
// - Re-enable store within four cycles frees section, not while busy.
// - Re-enable written during buffer load aborts it and drops the data.
// - Lock set store programs lock bits from low data; bit then clears.
// - Lock set load within three cycles returns lock or fuse bits.
// - Page write store writes the buffer to the pointed page; bit clears.
// - Page erase store erases the pointed page; bit clears.
// - Core halts for the whole operation on the halting section.
// - Arm alone: next store puts data pair into the pointed buffer word.
// - Arm opens a four-cycle store window, clears on store or timeout.
// - Arm stays set through erase, write and lock programming as the busy indication.
// - Low five bits change only for arm alone or arm plus one command.
// - Erase, write and lock programming each take 3.2 to 3.4 ms.
`timescale 1ns/100ps
module fspc_top import fspc_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYCLES_MIN
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register access from the core
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic reg_io_space,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Program memory store/load instructions
  input wire logic store_req,
  input wire logic load_req,
  input wire logic [15:0] ptr,
  input wire logic [7:0] data_lo,
  input wire logic [7:0] data_hi,
  input wire logic global_irq_en,
  input wire logic [1:0] boot_size_fuse,
  output logic load_special,
  output logic [7:0] load_data,
  output logic load_valid,
  output logic ready_irq,
  output logic core_halt,
  output logic conc_read_block,
  output logic [12:0] boot_start_addr,
  output logic [10:0] boot_words,
  // Flash array side
  input wire logic [7:0] lock_bits,
  input wire logic [7:0] fuse_bits,
  input wire logic [7:0] sig_row_byte,
  output logic buf_wr,
  output logic [WORD_SEL_WIDTH-1:0] buf_word_addr,
  output logic [15:0] buf_wr_data,
  output logic buf_discard,
  output logic erase_start,
  output logic write_start,
  output logic [PAGE_SEL_WIDTH-1:0] page_addr,
  output logic lock_start,
  output logic [7:0] lock_wr_data,
  output logic flash_busy
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic irq_en_ff;
  logic busy_flag_ff;
  logic sig_ff;
  logic reen_ff;
  logic lock_ff;
  logic write_ff;
  logic erase_ff;
  logic arm_ff;
  logic [2:0] win_ff;
  fspc_op_t op_ff;
  logic op_halt_ff;
  logic buf_loaded_ff;
  logic [7:0] rd_data_ff;
  logic load_special_ff;
  logic load_valid_ff;
  logic [7:0] load_data_ff;
  logic buf_wr_ff;
  logic [WORD_SEL_WIDTH-1:0] buf_word_ff;
  logic [15:0] buf_data_ff;
  logic buf_discard_ff;
  logic erase_start_ff;
  logic write_start_ff;
  logic lock_start_ff;
  logic [PAGE_SEL_WIDTH-1:0] page_ff;
  logic [7:0] lock_data_ff;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic csr_sel;
  logic csr_wr;
  logic [4:0] low5;
  logic low5_legal;
  logic op_active;
  logic store_ok;
  logic load_ok;
  logic timeout;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  logic page_in_conc;
  logic [PAGE_SEL_WIDTH-1:0] ptr_page;
  logic [7:0] csr_value;

  assign csr_sel = reg_io_space ? (reg_addr == CSR_IO_OFS) : (reg_addr == CSR_DATA_OFS);
  assign csr_wr = reg_wr_en && csr_sel;
  assign low5 = reg_wr_data[4:0];
  // Arm alone, or arm with exactly one command bit
  assign low5_legal = (low5 == 5'h01) || (low5 == 5'h03) || (low5 == 5'h05)
                      || (low5 == 5'h09) || (low5 == 5'h11);
  assign op_active = (op_ff != FSPC_OP_IDLE);
  // Pointer bits 15..14 never reach the decode
  assign ptr_page = ptr[PTR_PAGE_MSB:PTR_PAGE_LSB];
  assign store_ok = store_req && arm_ff && !op_active && (win_ff != 3'h0);
  assign load_ok = load_req && arm_ff && !op_active
                   && (win_ff > 3'(STORE_WINDOW_CYCLES - LOAD_WINDOW_CYCLES));
  assign timeout = arm_ff && !op_active && (win_ff == 3'h1) && !store_ok;
  assign timer_start = store_ok && (erase_ff || write_ff || lock_ff);

  fspc_section_map u_map (
    .boot_size_fuse,
    .page_sel(ptr_page),
    .boot_start_addr,
    .boot_words,
    .page_in_conc
  );

  fspc_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .ref_clk,
    .rst_b,
    .start(timer_start),
    .busy(timer_busy),
    .done(timer_done)
  );

  // ---------------------------------------------------------------
  // Control/status register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_ff <= CSR_RESET[BIT_IRQ_EN];
    end else if (csr_wr) begin
      irq_en_ff <= reg_wr_data[BIT_IRQ_EN];
    end
  end

  // Command bits: software writes are refused while a command is pending
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_ff <= CSR_RESET[BIT_ARM];
      erase_ff <= CSR_RESET[BIT_ERASE];
      write_ff <= CSR_RESET[BIT_WRITE];
      lock_ff <= CSR_RESET[BIT_LOCK];
      reen_ff <= CSR_RESET[BIT_REEN];
      sig_ff <= CSR_RESET[BIT_SIG];
    end else if (csr_wr && low5_legal && !arm_ff) begin
      arm_ff <= 1'b1;
      erase_ff <= low5[BIT_ERASE];
      write_ff <= low5[BIT_WRITE];
      lock_ff <= low5[BIT_LOCK];
      reen_ff <= low5[BIT_REEN];
      // Signature read is only accepted on top of arm alone
      sig_ff <= reg_wr_data[BIT_SIG] && (low5 == 5'h01);
    end else if (timer_done || timeout || (store_ok && !timer_start)) begin
      // Timed commands keep arm high until the timer ends
      arm_ff <= 1'b0;
      erase_ff <= 1'b0;
      write_ff <= 1'b0;
      lock_ff <= 1'b0;
      reen_ff <= 1'b0;
      sig_ff <= 1'b0;
    end
  end

  // Store window of four cycles after arming
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_ff <= 3'h0;
    end else if (csr_wr && low5_legal && !arm_ff) begin
      win_ff <= 3'(STORE_WINDOW_CYCLES);
    end else if (store_ok || timeout) begin
      win_ff <= 3'h0;
    end else if (win_ff != 3'h0) begin
      win_ff <= win_ff - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Operation tracking
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_ff <= FSPC_OP_IDLE;
      op_halt_ff <= 1'b0;
    end else if (timer_start) begin
      op_ff <= erase_ff ? FSPC_OP_ERASE : (write_ff ? FSPC_OP_WRITE : FSPC_OP_LOCK);
      op_halt_ff <= (erase_ff || write_ff) && !page_in_conc;
    end else if (timer_done) begin
      op_ff <= FSPC_OP_IDLE;
      op_halt_ff <= 1'b0;
    end
  end

  // Busy flag: a set by a new operation wins over any clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_flag_ff <= CSR_RESET[BIT_BUSY];
    end else if (timer_start && (erase_ff || write_ff) && page_in_conc) begin
      busy_flag_ff <= 1'b1;
    end else if (store_ok && reen_ff) begin
      busy_flag_ff <= 1'b0;
    end else if (store_ok && !erase_ff && !write_ff && !lock_ff && !reen_ff && !sig_ff) begin
      busy_flag_ff <= 1'b0;
    end
  end

  // Buffer holds data from the first fill until a page write or discard
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_loaded_ff <= 1'b0;
    end else if (store_ok && !erase_ff && !write_ff && !lock_ff && !reen_ff && !sig_ff) begin
      buf_loaded_ff <= 1'b1;
    end else if ((timer_start && write_ff) || buf_discard_ff) begin
      buf_loaded_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Flash side strobes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_wr_ff <= 1'b0;
      buf_word_ff <= '0;
      buf_data_ff <= 16'h0000;
    end else begin
      buf_wr_ff <= store_ok && !erase_ff && !write_ff && !lock_ff && !reen_ff && !sig_ff;
      if (store_ok) begin
        buf_word_ff <= ptr[WORD_SEL_WIDTH:PTR_WORD_LSB];
        buf_data_ff <= {data_hi, data_lo};
      end
    end
  end

  // A legal re-enable write during buffer fill drops the buffered words
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_discard_ff <= 1'b0;
    end else begin
      buf_discard_ff <= csr_wr && !arm_ff && low5_legal && low5[BIT_REEN] && buf_loaded_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      erase_start_ff <= 1'b0;
      write_start_ff <= 1'b0;
      lock_start_ff <= 1'b0;
      page_ff <= '0;
      lock_data_ff <= 8'h00;
    end else begin
      erase_start_ff <= timer_start && erase_ff;
      write_start_ff <= timer_start && write_ff;
      lock_start_ff <= timer_start && lock_ff;
      if (timer_start && (erase_ff || write_ff)) begin
        page_ff <= ptr_page;
      end
      if (timer_start && lock_ff) begin
        lock_data_ff <= data_lo;
      end
    end
  end

  // ---------------------------------------------------------------
  // Special loads
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      load_special_ff <= 1'b0;
      load_valid_ff <= 1'b0;
      load_data_ff <= 8'h00;
    end else begin
      load_valid_ff <= load_req;
      load_special_ff <= load_ok && (sig_ff || lock_ff);
      if (load_ok && sig_ff) begin
        load_data_ff <= sig_row_byte;
      end else if (load_ok && lock_ff) begin
        load_data_ff <= ptr[BYTE_SEL_BIT] ? fuse_bits : lock_bits;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  assign csr_value = {irq_en_ff, busy_flag_ff, sig_ff, reen_ff, lock_ff, write_ff, erase_ff, arm_ff};

  // Unselected reads return zero so other registers can be or-ed in
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_ff <= 8'h00;
    end else begin
      rd_data_ff <= (reg_rd_en && csr_sel) ? csr_value : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rd_data = rd_data_ff;
  assign ready_irq = irq_en_ff && global_irq_en && !arm_ff;
  assign core_halt = op_halt_ff;
  assign conc_read_block = busy_flag_ff;
  assign load_special = load_special_ff;
  assign load_data = load_data_ff;
  assign load_valid = load_valid_ff;
  assign buf_wr = buf_wr_ff;
  assign buf_word_addr = buf_word_ff;
  assign buf_wr_data = buf_data_ff;
  assign buf_discard = buf_discard_ff;
  assign erase_start = erase_start_ff;
  assign write_start = write_start_ff;
  assign lock_start = lock_start_ff;
  assign page_addr = page_ff;
  assign lock_wr_data = lock_data_ff;
  assign flash_busy = timer_busy;

endmodule

// [test/fspc_top_properties.sv]
/*
  Concurrent checks on the self-programming controller's ports.
  Assumes it is bound to fspc_top and shares its PROG_CYCLES value.
*/
`timescale 1ns/100ps
module fspc_top_properties import fspc_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYCLES_MIN
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic store_req,
  input wire logic load_req,
  input wire logic global_irq_en,
  input wire logic load_valid,
  input wire logic ready_irq,
  input wire logic core_halt,
  input wire logic conc_read_block,
  input wire logic [12:0] boot_start_addr,
  input wire logic [10:0] boot_words,
  input wire logic [1:0] boot_size_fuse,
  input wire logic buf_wr,
  input wire logic erase_start,
  input wire logic write_start,
  input wire logic lock_start,
  input wire logic [PAGE_SEL_WIDTH-1:0] page_addr,
  input wire logic flash_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Count busy cycles; too many for a repetition
  logic [31:0] busy_cnt_ff;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_ff <= '0;
    end else begin
      busy_cnt_ff <= flash_busy ? busy_cnt_ff + 32'd1 : 32'd0;
    end
  end

  a_prog_length: assert property ($fell(flash_busy) |-> busy_cnt_ff == PROG_CYCLES)
    else $error("programming time differs from the set count");
  a_start_busy: assert property ((erase_start || write_start || lock_start) |-> flash_busy)
    else $error("programming started without busy");
  a_start_cause: assert property ((buf_wr || erase_start || write_start || lock_start) |-> $past(store_req))
    else $error("flash action without a store");
  a_halt_page: assert property ((erase_start || write_start) && page_addr >= CONC_SECTION_PAGES |-> core_halt)
    else $error("core not halted for halting section");
  a_conc_page: assert property ((erase_start || write_start) && page_addr < CONC_SECTION_PAGES
    |-> conc_read_block && !core_halt)
    else $error("concurrent section not blocked");
  a_fill_frees: assert property (buf_wr |-> !conc_read_block)
    else $error("buffer load left section blocked");
  a_irq_gate: assert property (ready_irq |-> global_irq_en && !flash_busy)
    else $error("ready request while disabled or busy");
  a_load_answer: assert property (load_req |=> load_valid)
    else $error("load not answered");
  a_boot_map: assert property ({3'b000, boot_words} == (14'h0080 << (2'd3 - boot_size_fuse))
    && {1'b0, boot_start_addr} + {3'b000, boot_words} == 14'h2000)
    else $error("boot section size or start wrong");
endmodule

bind fspc_top fspc_top_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (.ref_clk, .rst_b, .store_req, .load_req,
  .global_irq_en, .load_valid, .ready_irq, .core_halt, .conc_read_block, .boot_start_addr, .boot_words,
  .boot_size_fuse, .buf_wr, .erase_start, .write_start, .lock_start, .page_addr, .flash_busy);

// [test/fspc_core_model.sv]
/*
  Core model: issues register accesses and program store/load requests.
  Assumes the bench calls one task at a time; lines are scrambled when idle.
*/
`timescale 1ns/100ps
module fspc_core_model import fspc_pkg::*; (
  input wire logic ref_clk,
  input wire logic core_halt,
  input wire logic [7:0] reg_rd_data,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic reg_io_space,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data,
  output logic store_req,
  output logic load_req,
  output logic [15:0] ptr,
  output logic [7:0] data_lo,
  output logic [7:0] data_hi
);
  initial begin
    {reg_wr_en, reg_rd_en, reg_io_space, reg_addr, reg_wr_data, store_req, load_req, ptr, data_lo, data_hi} = '0;
  end

  task automatic reg_op(input logic wr, io, input logic [7:0] a, d, output logic [7:0] q);
    // A halted core issues no register access
    while (core_halt) @(posedge ref_clk);
    @(posedge ref_clk);
    reg_wr_en <= wr;
    reg_rd_en <= !wr;
    reg_io_space <= io;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    reg_wr_data <= ~d;
    #1;
    q = reg_rd_data;
  endtask

  task automatic prog_op(input logic st, input logic [15:0] p, input logic [7:0] lo, hi);
    @(posedge ref_clk);
    store_req <= st;
    load_req <= !st;
    ptr <= st ? {p[15:1], 1'b0} : p;
    data_lo <= lo;
    data_hi <= hi;
    @(posedge ref_clk);
    store_req <= 1'b0;
    load_req <= 1'b0;
    ptr <= ~p;
    data_lo <= ~lo;
    data_hi <= ~hi;
    #1;
  endtask

  // Poll until the previous command is over
  task automatic wait_idle(output logic [7:0] q);
    q = 8'h01;
    for (int i = 0; i < 100 && q[BIT_ARM] !== 1'b0; i++) begin
      reg_op(1'b0, 1'b0, CSR_DATA_OFS, 8'h00, q);
    end
  endtask
endmodule

// [test/flash_self_program_control_tb.sv]
/*
  Bench for fspc_top with a short programming time.
  Assumes the core model and the bound checker.
*/
`timescale 1ns/100ps
module flash_self_program_control_tb;
  import fspc_pkg::*;
  typedef struct packed {
    logic [7:0] csr;
    logic [15:0] p;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [3:0] kind;
    logic [15:0] v1;
    logic [15:0] v2;
  } fspc_row_t;
  // Kind is {fill, erase, write, lock}; rows keep the busy flag for the last
  localparam fspc_row_t ROWS [4] = '{
    '{8'h89, 16'h1234, 8'hc3, 8'h5a, 4'b0001, 16'h00c3, 16'h0000},
    '{8'h85, 16'hf800, 8'h11, 8'h22, 4'b0010, 16'h0070, 16'h0002},
    '{8'h81, 16'hc07e, 8'ha5, 8'h3c, 4'b1000, 16'h3ca5, 16'h003f},
    '{8'h83, 16'h3780, 8'h00, 8'h00, 4'b0100, 16'h006f, 16'h0001}};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic global_irq_en = 1'b1;
  logic [1:0] boot_size_fuse = 2'b11;
  logic [7:0] lock_bits = 8'h3c;
  logic [7:0] fuse_bits = 8'hd9;
  logic [7:0] sig_row_byte = 8'h1e;
  logic reg_wr_en, reg_rd_en, reg_io_space, store_req, load_req, load_special, load_valid, ready_irq;
  logic core_halt, conc_read_block, buf_wr, buf_discard, erase_start, write_start, lock_start, flash_busy;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, data_lo, data_hi, load_data, lock_wr_data, q;
  logic [15:0] ptr, buf_wr_data;
  logic [12:0] boot_start_addr;
  logic [10:0] boot_words;
  logic [WORD_SEL_WIDTH-1:0] buf_word_addr;
  logic [PAGE_SEL_WIDTH-1:0] page_addr;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_disc = 0;

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (buf_discard === 1'b1) n_disc++;

  fspc_core_model u_core (.ref_clk, .core_halt, .reg_rd_data, .reg_wr_en, .reg_rd_en, .reg_io_space, .reg_addr,
    .reg_wr_data, .store_req, .load_req, .ptr, .data_lo, .data_hi);
  fspc_top #(.PROG_CYCLES(20)) u_dut (.ref_clk, .rst_b, .reg_wr_en, .reg_rd_en, .reg_io_space, .reg_addr,
    .reg_wr_data, .reg_rd_data, .store_req, .load_req, .ptr, .data_lo, .data_hi, .global_irq_en, .boot_size_fuse,
    .load_special, .load_data, .load_valid, .ready_irq, .core_halt, .conc_read_block, .boot_start_addr,
    .boot_words, .lock_bits, .fuse_bits, .sig_row_byte, .buf_wr, .buf_word_addr, .buf_wr_data, .buf_discard,
    .erase_start, .write_start, .page_addr, .lock_start, .lock_wr_data, .flash_busy);

  task automatic chk(input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Watchdog: run needs under 5000 cycles
  // --------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end

  task automatic cmd(input logic [7:0] c);
    u_core.reg_op(1'b1, 1'b0, CSR_DATA_OFS, c, q);
  endtask

  function automatic logic [15:0] pulses();
    return {12'h000, buf_wr, erase_start, write_start, lock_start};
  endfunction

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    u_core.reg_op(1'b0, 1'b0, CSR_DATA_OFS, 8'h00, q);
    chk({8'h00, q}, {8'h00, CSR_RESET});
    u_core.reg_op(1'b1, 1'b1, 8'h37, 8'h80, q);
    u_core.reg_op(1'b0, 1'b0, 8'h57, 8'h00, q);
    chk({8'h00, q}, 16'h0080);
    chk({15'h0000, ready_irq}, 16'h0001);
    u_core.reg_op(1'b0, 1'b0, 8'h58, 8'h00, q);
    chk({8'h00, q}, 16'h0000);
    for (int f = 0; f < 4; f++) begin
      @(posedge ref_clk) boot_size_fuse <= 2'(f);
      @(posedge ref_clk) #1;
      chk({3'b000, boot_start_addr}, 16'(16'h2000 - (16'h0080 << (3 - f))));
    end
    foreach (ROWS[i]) begin
      cmd(ROWS[i].csr);
      u_core.prog_op(1'b1, ROWS[i].p, ROWS[i].lo, ROWS[i].hi);
      chk(pulses(), {12'h000, ROWS[i].kind});
      chk(ROWS[i].kind[3] ? buf_wr_data : ROWS[i].kind[0] ? {8'h00, lock_wr_data} : {9'h000, page_addr},
          ROWS[i].v1);
      chk(ROWS[i].kind[3] ? {10'h000, buf_word_addr} : {14'h0000, core_halt, conc_read_block},
          ROWS[i].v2);
      u_core.reg_op(1'b0, 1'b0, CSR_DATA_OFS, 8'h00, q);
      if (ROWS[i].v2 != 16'h0002) chk({15'h0000, q[BIT_ARM]}, {15'h0000, |ROWS[i].kind[2:0]});
      u_core.wait_idle(q);
      chk({8'h00, q & 8'h7f}, {8'h00, ROWS[i].kind[2] ? 8'h40 : 8'h00});
    end
    cmd(8'h91);
    u_core.prog_op(1'b1, 16'h0000, 8'h00, 8'h00);
    u_core.wait_idle(q);
    chk({7'h00, q[BIT_BUSY], conc_read_block, 7'h00}, 16'h0000);
    cmd(8'h81);
    repeat (2) @(posedge ref_clk);
    u_core.prog_op(1'b1, 16'h0004, 8'h11, 8'h22);
    chk((pulses() << 8) | {10'h000, buf_word_addr}, 16'h0802);
    cmd(8'h83);
    repeat (3) @(posedge ref_clk);
    u_core.prog_op(1'b1, 16'h0080, 8'h00, 8'h00);
    chk(pulses(), 16'h0000);
    u_core.wait_idle(q);
    cmd(8'h87);
    u_core.reg_op(1'b0, 1'b0, CSR_DATA_OFS, 8'h00, q);
    chk({8'h00, q & 8'h1f}, 16'h0000);
    cmd(8'ha1);
    u_core.prog_op(1'b0, 16'h0001, 8'h00, 8'h00);
    chk({7'h00, load_special, load_data}, {8'h01, sig_row_byte});
    u_core.wait_idle(q);
    cmd(8'ha1);
    u_core.prog_op(1'b1, 16'h0040, 8'h00, 8'h00);
    chk(pulses(), 16'h0000);
    u_core.wait_idle(q);
    for (int z = 0; z < 2; z++) begin
      cmd(8'h89);
      u_core.prog_op(1'b0, 16'(z), 8'h00, 8'h00);
      chk({8'h00, load_data}, {8'h00, z ? fuse_bits : lock_bits});
      u_core.wait_idle(q);
      chk({8'h00, q & 8'h1f}, 16'h0000);
    end
    cmd(8'h81);
    u_core.prog_op(1'b1, 16'h000a, 8'h77, 8'h66);
    u_core.wait_idle(q);
    n_disc = 0;
    cmd(8'h91);
    u_core.prog_op(1'b1, 16'h0000, 8'h00, 8'h00);
    u_core.wait_idle(q);
    chk(16'(n_disc), 16'h0001);
    @(posedge ref_clk) global_irq_en <= 1'b0;
    @(posedge ref_clk) #1;
    chk({15'h0000, ready_irq}, 16'h0000);
    give_verdict();
  end
endmodule
